// file: design/vic_top.sv
// Vectored interrupt controller: arbitration, vector fetch and fixed-latency entry.
// ******************************************************************
// What this block does
// - Many peripheral request lines merge into one request to the core.
// - Each maskable source carries one of seven software-set priority levels.
// - At equal level the lower vector wins; vector zero beats all.
// - Primary table starts at program word 000004h.
// - Primary table has 126 entries: eight traps then 118 interrupts.
// - Each entry gives a 24-bit handler address; execution jumps there.
// - Up to 61 maskable sources and 5 nonmaskable traps exist.
// - Alternate-select bit 15 of control register two picks alternate table.
// - Alternate table follows the primary with identical slot order.
// - Request n is vector n+8 at 0x14+2n or 0x114+2n.
// - Every source owns its own vector entry.
// - Entry and return latencies are fixed cycle counts.
// - Reset bypasses the controller, clears state, program counter goes to zero.
// ******************************************************************
module vic_top
  import vic_pkg::*;
#(
  parameter int                   NUM_IRQ  = VIC_IRQ_SLOTS,
  parameter int                   NUM_TRAP = VIC_MAX_TRAP,
  parameter logic [NUM_IRQ-1:0]   IRQ_IMPL = '1
) (
  input  wire logic                              sys_clk_i,
  input  wire logic                              rst_n_i,
  input  wire logic [NUM_IRQ-1:0]                irq_req_i,
  input  wire logic [NUM_IRQ-1:0]                irq_en_i,
  input  wire logic [NUM_IRQ-1:0][VIC_PRIO_W-1:0] irq_prio_i,
  input  wire logic [NUM_TRAP-1:0]               trap_req_i,
  input  wire logic [VIC_CPRIO_W-1:0]            cpu_prio_i,
  input  wire logic [15:0]                       second_interrupt_control_reg_i,
  input  wire logic                              cpu_ack_i,
  input  wire logic                              cpu_ret_i,
  input  wire logic [VIC_ADDR_W-1:0]             tbl_data_i,
  output logic                                   cpu_irq_o,
  output logic [VIC_IDX_W-1:0]                   vec_num_o,
  output logic                                   taken_o,
  output vic_fetch_t                             fetch_o,
  output vic_entry_t                             entry_o,
  output logic                                   ret_done_o
);

  // ****************************************************************
  // Arbitration
  // ****************************************************************
  // The loops run from the top index down and take ties, so the lowest
  // index at the highest level is left standing. Traps are checked last
  // and therefore always override maskable sources.
  function automatic vic_win_t vic_pick(
    input logic [NUM_IRQ-1:0]                 pend,
    input logic [NUM_IRQ-1:0][VIC_PRIO_W-1:0] lvl,
    input logic [NUM_TRAP-1:0]                trap
  );
    vic_win_t w;
    w = '0;
    for (int i = NUM_IRQ - 1; i >= 0; i--) begin
      if (pend[i] && lvl[i] != VIC_LVL_OFF && {1'b0, lvl[i]} >= w.prio) begin
        w.found = 1'b1;
        w.trap  = 1'b0;
        w.idx   = 7'(i);
        w.prio  = {1'b0, lvl[i]};
      end
    end
    for (int i = NUM_TRAP - 1; i >= 0; i--) begin
      if (trap[i]) begin
        w.found = 1'b1;
        w.trap  = 1'b1;
        w.idx   = 7'(i);
        w.prio  = VIC_TRAP_TOP - 4'(i);
      end
    end
    return w;
  endfunction

  function automatic logic [VIC_IDX_W-1:0] vic_vec(input vic_win_t w);
    return w.trap ? w.idx : w.idx + VIC_IRQ_VOFS;
  endfunction

  function automatic logic [VIC_ADDR_W-1:0] vic_slot(
    input logic                 alt,
    input logic [VIC_IDX_W-1:0] vec
  );
    logic [VIC_ADDR_W-1:0] base;
    base = alt ? VIC_ALT_BASE : VIC_PRI_BASE;
    return base + {16'h0000, vec, 1'b0};
  endfunction

  // ****************************************************************
  // Decode
  // ****************************************************************
  vic_state_t                     st_r;
  vic_state_t                     st_nxt;
  vic_win_t                       win_r;
  logic [3:0]                     cnt_r;
  logic [VIC_ADDR_W-1:0]          hdl_r;
  logic                           irq_nxt;

  wire logic [NUM_IRQ-1:0] pend_w   = irq_req_i & irq_en_i & IRQ_IMPL;
  wire vic_win_t           pick_w   = vic_pick(pend_w, irq_prio_i, trap_req_i);
  wire logic               pend_any = |pend_w | |trap_req_i;
  wire logic               alt_w    = second_interrupt_control_reg_i[VIC_ALT_BIT];
  wire logic               take_w   = (st_r == VIC_ST_IDLE) && cpu_irq_o && cpu_ack_i;
  wire logic               ent_w    = (st_r == VIC_ST_FETCH) && (cnt_r == VIC_ENTRY_CYC - 4'h1);
  wire logic               rdone_w  = (st_r == VIC_ST_RETURN) && (cnt_r == VIC_RET_CYC - 4'h1);
  wire logic               cap_w    = (st_r == VIC_ST_FETCH) && (cnt_r == VIC_TBL_LAT);

  // Only a winner that outranks the core is offered; while a handler is
  // in flight no new request is raised, so the fixed timing is never cut.
  assign irq_nxt = (st_r == VIC_ST_IDLE) && !take_w && pick_w.found
                   && (pick_w.prio > cpu_prio_i);

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      VIC_ST_IDLE: begin
        if (take_w) begin
          st_nxt = VIC_ST_FETCH;
        end
      end
      VIC_ST_FETCH: begin
        if (ent_w) begin
          st_nxt = VIC_ST_SERVICE;
        end
      end
      VIC_ST_SERVICE: begin
        if (cpu_ret_i) begin
          st_nxt = VIC_ST_RETURN;
        end
      end
      VIC_ST_RETURN: begin
        if (rdone_w) begin
          st_nxt = VIC_ST_IDLE;
        end
      end
      default: begin
        st_nxt = VIC_ST_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  // Reset drops everything in flight and parks the entry port on the reset
  // address; no vector is fetched for it.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r  <= VIC_ST_IDLE;
      cnt_r <= 4'h0;
    end else begin
      st_r <= st_nxt;
      if (st_nxt != st_r) begin
        cnt_r <= 4'h0;
      end else begin
        cnt_r <= cnt_r + 4'h1;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cpu_irq_o <= 1'b0;
      win_r     <= '0;
      vec_num_o <= 7'h00;
    end else begin
      cpu_irq_o <= irq_nxt;
      if (st_r == VIC_ST_IDLE && !take_w) begin
        win_r     <= pick_w;
        vec_num_o <= vic_vec(pick_w);
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      taken_o <= 1'b0;
      fetch_o <= '0;
      hdl_r   <= VIC_RESET_PC;
    end else begin
      taken_o      <= take_w;
      fetch_o.rd   <= take_w;
      if (take_w) begin
        fetch_o.addr <= vic_slot(alt_w, vec_num_o);
      end
      if (cap_w) begin
        hdl_r <= tbl_data_i;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      entry_o    <= '{load: 1'b0, pc: VIC_RESET_PC};
      ret_done_o <= 1'b0;
    end else begin
      entry_o.load <= ent_w;
      if (ent_w) begin
        entry_o.pc <= hdl_r;
      end
      ret_done_o <= rdone_w;
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  irq_merge_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    cpu_irq_o |-> $past(pend_any))
    else $error("Request raised with nothing pending.");

  irq_above_core_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    cpu_irq_o |-> win_r.prio > $past(cpu_prio_i))
    else $error("Request raised below core priority.");

  vec_map_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (cpu_irq_o && !win_r.trap) |-> vec_num_o == win_r.idx + VIC_IRQ_VOFS)
    else $error("Interrupt vector number is not request plus eight.");

  tie_order_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (cpu_irq_o && !win_r.trap && win_r.idx != 7'h00 && $past(pend_w[0]))
    |-> {1'b0, $past(irq_prio_i[0])} < win_r.prio)
    else $error("Lower vector lost a tie at equal level.");

  trap_first_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (cpu_irq_o && $past(|trap_req_i)) |-> win_r.trap)
    else $error("Maskable source beat a pending trap.");

  table_addr_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    fetch_o.rd |-> fetch_o.addr ==
      ($past(alt_w) ? VIC_ALT_BASE : VIC_PRI_BASE) + {16'h0000, $past(vec_num_o), 1'b0})
    else $error("Vector fetch address is wrong for the selected table.");

  entry_fixed_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    take_w |-> !entry_o.load [*5] ##1 entry_o.load)
    else $error("Handler entry latency is not fixed.");

  return_fixed_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (st_r == VIC_ST_SERVICE && cpu_ret_i) |-> ##4 ret_done_o)
    else $error("Return latency is not fixed.");

  entry_pc_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    entry_o.load |-> entry_o.pc == $past(tbl_data_i, 3))
    else $error("Handler address differs from the fetched entry.");

  reset_pc_a: assert property (@(posedge sys_clk_i)
    !$past(rst_n_i) |-> (entry_o.pc == VIC_RESET_PC && !cpu_irq_o && !entry_o.load))
    else $error("Reset did not park the program counter at zero.");

  take_pulse_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    taken_o |=> !taken_o)
    else $error("Take pulse lasted more than one cycle.");

  fetch_take_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    taken_o |-> fetch_o.rd)
    else $error("Accepted request did not start a vector fetch.");

  load_pulse_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    entry_o.load |=> !entry_o.load)
    else $error("Handler load lasted more than one cycle.");

  ret_pulse_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    ret_done_o |=> !ret_done_o)
    else $error("Return pulse lasted more than one cycle.");

  ret_idle_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    ret_done_o |-> st_r == VIC_ST_IDLE)
    else $error("Return finished without going idle.");

  irq_drop_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    taken_o |-> !cpu_irq_o)
    else $error("Request still raised after it was accepted.");

  busy_quiet_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (st_r != VIC_ST_IDLE) |-> !cpu_irq_o)
    else $error("Request raised while a handler is in flight.");

  vec_frozen_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (st_r != VIC_ST_IDLE) |-> $stable(vec_num_o))
    else $error("Vector number moved while a handler is in flight.");

  pc_hold_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !entry_o.load |-> $stable(entry_o.pc))
    else $error("Handler address moved without a load.");

  prim_range_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (fetch_o.rd && !$past(alt_w)) |-> fetch_o.addr < VIC_ALT_BASE)
    else $error("Primary fetch reached into the alternate table.");

  alt_range_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (fetch_o.rd && $past(alt_w)) |-> fetch_o.addr >= VIC_ALT_BASE)
    else $error("Alternate fetch fell below the alternate table.");

  trap_vec_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (cpu_irq_o && win_r.trap) |-> vec_num_o == win_r.idx)
    else $error("Trap vector number is not its own slot.");

  trap_level_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    (cpu_irq_o && win_r.trap) |-> win_r.prio == VIC_TRAP_TOP - {1'b0, win_r.idx[2:0]})
    else $error("Trap level does not follow its slot.");

  hdl_capture_a: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    cap_w |=> hdl_r == $past(tbl_data_i))
    else $error("Handler address not taken from program memory.");

endmodule

// file: pkg/vic_pkg.sv
// Constants and carrier types of the vectored interrupt controller.
package vic_pkg;

  // ****************************************************************
  // Table geometry
  // ****************************************************************
  localparam int          VIC_PRIO_W     = 3;
  localparam int          VIC_CPRIO_W    = 4;
  localparam int          VIC_IDX_W      = 7;
  localparam int          VIC_ADDR_W     = 24;
  localparam int          VIC_NUM_VEC    = 126;
  localparam int          VIC_TRAP_SLOTS = 8;
  localparam int          VIC_IRQ_SLOTS  = 118;
  localparam int          VIC_MAX_SRC    = 61;
  localparam int          VIC_MAX_TRAP   = 5;
  localparam int          VIC_ALT_BIT    = 15;
  localparam logic [23:0] VIC_PRI_BASE   = 24'h000004;
  localparam logic [23:0] VIC_ALT_BASE   = 24'h000104;
  localparam logic [23:0] VIC_RESET_PC   = 24'h000000;
  localparam logic [6:0]  VIC_IRQ_VOFS   = 7'h08;
  localparam logic [2:0]  VIC_LVL_OFF    = 3'h0;
  localparam logic [3:0]  VIC_TRAP_TOP   = 4'hF;

  // ****************************************************************
  // Fixed latencies in clock cycles
  // ****************************************************************
  localparam logic [3:0]  VIC_TBL_LAT    = 4'h1;
  localparam logic [3:0]  VIC_ENTRY_CYC  = 4'h4;
  localparam logic [3:0]  VIC_RET_CYC    = 4'h3;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [3:0] {
    VIC_ST_IDLE    = 4'h1,
    VIC_ST_FETCH   = 4'h2,
    VIC_ST_SERVICE = 4'h4,
    VIC_ST_RETURN  = 4'h8
  } vic_state_t;

  typedef struct packed {
    logic       found;
    logic       trap;
    logic [6:0] idx;
    logic [3:0] prio;
  } vic_win_t;

  typedef struct packed {
    logic        rd;
    logic [23:0] addr;
  } vic_fetch_t;

  typedef struct packed {
    logic        load;
    logic [23:0] pc;
  } vic_entry_t;

endpackage

// file: sim/vectored_interrupt_controller_tb_top.sv
// Self-checking testbench of the vectored interrupt controller.
module vectored_interrupt_controller_tb_top
  import vic_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // Signals and instances
  // ****************************************************************
  localparam logic [23:0] HXOR = 24'h5A5A5A;
  logic              sys_clk_i = 1'b0;
  logic              rst_n_i, cpu_ack_i, cpu_ret_i;
  logic [117:0]      irq_req_i, irq_en_i;
  logic [117:0][2:0] irq_prio_i;
  logic [4:0]        trap_req_i;
  logic [3:0]        cpu_prio_i;
  logic [15:0]       ctl2;
  logic [23:0]       tbl_data;
  logic              cpu_irq_o, taken_o, ret_done_o;
  logic [6:0]        vec_num_o;
  vic_fetch_t        fetch_o;
  vic_entry_t        entry_o;
  int                mismatches, checks;

  always #25 sys_clk_i = ~sys_clk_i;

  vic_top dut (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .irq_req_i(irq_req_i), .irq_en_i(irq_en_i),
    .irq_prio_i(irq_prio_i), .trap_req_i(trap_req_i), .cpu_prio_i(cpu_prio_i),
    .second_interrupt_control_reg_i(ctl2), .cpu_ack_i(cpu_ack_i), .cpu_ret_i(cpu_ret_i),
    .tbl_data_i(tbl_data), .cpu_irq_o(cpu_irq_o), .vec_num_o(vec_num_o), .taken_o(taken_o),
    .fetch_o(fetch_o), .entry_o(entry_o), .ret_done_o(ret_done_o)
  );

  vic_pmem_model #(.HANDLER_XOR(HXOR)) pmem (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .fetch_i(fetch_o), .tbl_data_o(tbl_data)
  );

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic close_out();
    if (mismatches == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    checks++;
    if (got !== exp) begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      mismatches++;
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
  endtask

  task automatic clr();
    irq_req_i  <= '0;
    irq_en_i   <= '1;
    irq_prio_i <= '0;
    trap_req_i <= 5'h00;
    cpu_prio_i <= 4'h0;
    ctl2       <= 16'h0000;
  endtask

  task automatic raise(input int n, input logic [2:0] lvl);
    irq_req_i[n]  <= 1'b1;
    irq_prio_i[n] <= lvl;
  endtask

  // The request shows one cycle after the inputs that cause it.
  task automatic offer(input logic exp_irq, input logic [6:0] vec);
    tick(1);
    #1 chk("cpu_irq_o", exp_irq, cpu_irq_o);
    if (exp_irq) chk("vec_num_o", vec, vec_num_o);
  endtask

  task automatic serve(input logic [6:0] vec, input logic alt);
    logic [23:0] adr;
    adr = (alt ? 24'h000104 : 24'h000004) + {16'h0, vec, 1'b0};
    tick(1);
    cpu_ack_i <= 1'b1;
    tick(1);
    cpu_ack_i  <= 1'b0;
    irq_req_i  <= '0;
    trap_req_i <= 5'h00;
    #1 chk("taken_o", 1'b1, taken_o);
    chk("fetch rd", 1'b1, fetch_o.rd);
    chk("fetch addr", adr, fetch_o.addr);
    chk("cpu_irq_o", 1'b0, cpu_irq_o);
    tick(3);
    #1 chk("load early", 1'b0, entry_o.load);
    tick(1);
    #1 chk("load", 1'b1, entry_o.load);
    chk("pc", (alt ? adr - 24'h000100 : adr) ^ HXOR, entry_o.pc);
    tick(1);
    cpu_ret_i <= 1'b1;
    tick(1);
    cpu_ret_i <= 1'b0;
    tick(2);
    #1 chk("ret early", 1'b0, ret_done_o);
    tick(1);
    #1 chk("ret_done_o", 1'b1, ret_done_o);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic s_tie();
    tick(1);
    clr();
    raise(0, 3'h4);
    raise(117, 3'h4);
    offer(1'b1, 7'h08);
    serve(7'h08, 1'b0);
  endtask

  task automatic s_levels();
    for (int l = 1; l < 8; l++) begin
      tick(1);
      raise(5, 3'(l));
      cpu_prio_i <= 4'(l);
      offer(1'b0, 7'h0D);
      tick(1);
      cpu_prio_i <= 4'(l - 1);
      offer(1'b1, 7'h0D);
    end
  endtask

  task automatic s_rank();
    tick(1);
    clr();
    raise(2, 3'h3);
    raise(90, 3'h6);
    offer(1'b1, 7'h62);
    tick(1);
    irq_en_i[90] <= 1'b0;
    offer(1'b1, 7'h0A);
    tick(1);
    irq_prio_i[2] <= 3'h0;
    offer(1'b0, 7'h00);
  endtask

  // Trap two sits at level 13, so a core at 13 holds it off and one at 12 does not.
  task automatic s_trap();
    tick(1);
    clr();
    raise(3, 3'h7);
    trap_req_i <= 5'h14;
    cpu_prio_i <= 4'hD;
    offer(1'b0, 7'h00);
    tick(1);
    cpu_prio_i <= 4'hC;
    offer(1'b1, 7'h02);
    serve(7'h02, 1'b0);
  endtask

  task automatic s_alt();
    tick(1);
    clr();
    raise(117, 3'h1);
    ctl2 <= 16'h8000;
    offer(1'b1, 7'h7D);
    serve(7'h7D, 1'b1);
  endtask

  // A reset in mid-run must clear a pending offer and the handler address.
  task automatic s_rerun_reset();
    tick(1);
    clr();
    raise(3, 3'h5);
    offer(1'b1, 7'h0B);
    tick(1);
    rst_n_i <= 1'b0;
    tick(1);
    #1 chk("pc reset", 24'h000000, entry_o.pc);
    chk("irq reset", 1'b0, cpu_irq_o);
    tick(1);
    rst_n_i <= 1'b1;
    offer(1'b1, 7'h0B);
  endtask

  initial begin
    rst_n_i   = 1'b0;
    cpu_ack_i = 1'b0;
    cpu_ret_i = 1'b0;
    clr();
    tick(15);
    #1 chk("pc reset", 24'h000000, entry_o.pc);
    tick(1);
    rst_n_i <= 1'b1;
    s_tie();
    s_levels();
    s_rank();
    s_trap();
    s_alt();
    s_rerun_reset();
    close_out();
  end

  initial begin
    repeat (20000) @(posedge sys_clk_i);
    mismatches++;
    close_out();
  end
endmodule

// file: sim/vic_pmem_model.sv
// Program-memory model that answers the controller's vector-entry reads.
module vic_pmem_model
  import vic_pkg::*;
#(
  parameter logic [23:0] HANDLER_XOR = 24'h5A5A5A,
  parameter logic [23:0] DEFAULT_ISR = 24'h000200
) (
  input  wire logic       sys_clk_i,
  input  wire logic       rst_n_i,
  input  wire vic_fetch_t fetch_i,
  output logic [23:0]     tbl_data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // Table storage
  // ****************************************************************
  logic        in_tbl;
  logic [23:0] src_adr;

  // Software keeps the alternate table as a copy of the primary one.
  assign src_adr = (fetch_i.addr >= 24'h000104) ? fetch_i.addr - 24'h000100
                                                : fetch_i.addr;

  // Both tables span 0x000004 up to 0x0001FF in one address space.
  assign in_tbl = (fetch_i.addr >= 24'h000004) && (fetch_i.addr < 24'h000200);

  // The word is valid for one cycle only; after that it is inverted every cycle, so stale data matches again every second cycle.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tbl_data_o <= 24'h000000;
    end else if (fetch_i.rd) begin
      tbl_data_o <= in_tbl ? (src_adr ^ HANDLER_XOR) : DEFAULT_ISR;
    end else begin
      tbl_data_o <= ~tbl_data_o;
    end
  end
endmodule
